/* tba_defines.svh */
// offsets, field positions, landmark values and fixed counts of the timer byte path
`ifndef TBA_DEFINES_SVH
`define TBA_DEFINES_SVH

// byte locations on the processor port
`define TBA_A_CNT_L 4'h0
`define TBA_A_CNT_H 4'h1
`define TBA_A_CMPA_L 4'h2
`define TBA_A_CMPA_H 4'h3
`define TBA_A_CMPB_L 4'h4
`define TBA_A_CMPB_H 4'h5
`define TBA_A_CMPC_L 4'h6
`define TBA_A_CMPC_H 4'h7
`define TBA_A_CAP_L 4'h8
`define TBA_A_CAP_H 4'h9
`define TBA_A_CTRL_A 4'ha
`define TBA_A_CTRL_B 4'hb
`define TBA_A_CTRL_C 4'hc
`define TBA_A_FLAG 4'hd
`define TBA_A_MASK 4'he

// control A fields
`define TBA_CA_TOP_HI 2
`define TBA_CA_TOP_LO 0
`define TBA_CA_PWM 3
// control B fields
`define TBA_CB_CS_HI 2
`define TBA_CB_CS_LO 0
`define TBA_CB_DOWN 3
`define TBA_CB_NCE 4
`define TBA_CB_EDGE 5
`define TBA_CB_ACIC 6

// top selection codes
`define TBA_TOP_MAX 3'h0
`define TBA_TOP_FF 3'h1
`define TBA_TOP_1FF 3'h2
`define TBA_TOP_3FF 3'h3
`define TBA_TOP_CMPA 3'h4
`define TBA_TOP_CAP 3'h5

// tick source codes
`define TBA_CS_STOP 3'h0
`define TBA_CS_CLK 3'h1
`define TBA_CS_PRE 3'h2
`define TBA_CS_EXT_FALL 3'h3
`define TBA_CS_EXT_RISE 3'h4

// flag and mask bit positions
`define TBA_F_OVF 0
`define TBA_F_CMPA 1
`define TBA_F_CAP 4
`define TBA_NFLAG 5
`define TBA_NCH 3

// count landmarks
`define TBA_BOTTOM 16'h0000
`define TBA_MAX 16'hffff
`define TBA_FIX_FF 16'h00ff
`define TBA_FIX_1FF 16'h01ff
`define TBA_FIX_3FF 16'h03ff

// samples that must agree before the filtered capture input moves
`define TBA_NC_SAMPLES 4

`endif

/* tba_pkg.sv */
// state types of the timer byte path modules
`include "tba_defines.svh"

package tba_pkg;

  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic tick;
  } tba_tick_t;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic cmp_s1;
    logic cmp_s2;
    logic [`TBA_NC_SAMPLES-1:0] hist;
    logic filt;
    logic prev;
    logic evt;
  } tba_filt_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] temp;
    logic [`TBA_NCH-1:0][15:0] cmp_buf;
    logic [`TBA_NCH-1:0][15:0] cmp_act;
    logic [15:0] cap;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [`TBA_NFLAG-1:0] flag;
    logic [`TBA_NFLAG-1:0] mask;
    logic [`TBA_NFLAG-1:0] irq;
    logic [`TBA_NCH-1:0] match;
    logic [`TBA_NCH-1:0] oc;
    logic [7:0] rdata;
    logic at_bottom;
    logic at_max;
    logic at_top;
  } tba_core_t;

endpackage

/* tba_tick_sel.sv */
// tick source and edge selection for the counter
`timescale 1ns/1ps
`default_nettype none
`include "tba_defines.svh"

module tba_tick_sel
  import tba_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] sel,
  input wire logic prescale_tick,
  input wire logic ext_pin,
  output logic tick
);

  tba_tick_t s_q, s_d;

  // the pin is asynchronous, so edges are seen on the second stage only
  always_comb begin
    s_d = s_q;
    s_d.ext_s1 = ext_pin;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_prev = s_q.ext_s2;
    unique case (sel)
      `TBA_CS_CLK: s_d.tick = 1'b1;
      `TBA_CS_PRE: s_d.tick = prescale_tick;
      `TBA_CS_EXT_FALL: s_d.tick = s_q.ext_prev & ~s_q.ext_s2;
      `TBA_CS_EXT_RISE: s_d.tick = ~s_q.ext_prev & s_q.ext_s2;
      default: s_d.tick = 1'b0; // stop and unused codes give no tick
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  // (RULE_03) stopped source idles
  a_stop_no_tick: assert property (@(posedge clk) disable iff (rst) // RULE_03
    sel == `TBA_CS_STOP |=> !tick) else $error("tick seen with no source selected");

endmodule

`default_nettype wire

/* tba_cap_filter.sv */
// capture source select, noise canceller and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "tba_defines.svh"

module tba_cap_filter
  import tba_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic comp,
  input wire logic use_comp,
  input wire logic nc_en,
  input wire logic rising,
  input wire logic enable,
  output logic evt
);

  tba_filt_t s_q, s_d;
  logic sample;

  // both sources pass two flops; switching source may itself look like an edge
  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = pin;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.cmp_s1 = comp;
    s_d.cmp_s2 = s_q.cmp_s1;
    sample = use_comp ? s_q.cmp_s2 : s_q.pin_s2;
    s_d.hist = {s_q.hist[`TBA_NC_SAMPLES-2:0], sample};
    if (!nc_en) begin
      s_d.filt = sample;
    end else if (&s_q.hist || ~|s_q.hist) begin
      s_d.filt = s_q.hist[0]; // all samples agree
    end
    s_d.prev = s_q.filt;
    s_d.evt = enable && (s_q.filt != s_q.prev) && (s_q.filt == rising);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign evt = s_q.evt;

  // (RULE_06) filter needs agreeing samples
  a_filter_agree: assert property (@(posedge clk) disable iff (rst) // RULE_06
    nc_en && $past(nc_en) && (s_q.filt != $past(s_q.filt)) |->
    ($past(s_q.hist) == '0 || $past(s_q.hist) == '1))
    else $error("filtered input moved without agreeing samples");

endmodule

`default_nettype wire

/* tba_timer16.sv */
// 16-bit timer core with shared high-byte latch on an 8-bit processor port
// Behaviour
// (RULE_01) counter, compares, capture 16-bit; controls 8-bit
// (RULE_02) every request flagged, each separately masked
// (RULE_03) tick from clock, prescaler or pin
// (RULE_04) clock select picks source and edge
// (RULE_05) compares match counter, set flag, drive pin
// (RULE_06) edge from pin/comparator captures count, filtered
// (RULE_07) compare A as PWM top: no A output
// (RULE_08) signal BOTTOM when count becomes zero
// (RULE_09) signal MAX when count becomes all ones
// (RULE_10) TOP is fixed value, compare A or capture
// (RULE_11) one shared high-byte latch per timer
// (RULE_12) low write loads latch and byte together
// (RULE_13) low read copies high byte into latch
// (RULE_14) compare high reads bypass the latch
// (RULE_15) processor writes high first, reads low first
// (RULE_16) processor keeps 16-bit pairs uninterrupted
// (RULE_17) counter high location reaches the latch
// (RULE_18) high write changes only the latch
`timescale 1ns/1ps
`default_nettype none
`include "tba_defines.svh"

module tba_timer16
  import tba_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  input wire logic PRESCALE_TICK,
  input wire logic EXTERNAL_COUNT_PIN,
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic COMPARATOR_OUT,
  output logic [7:0] BUS_RDATA,
  output logic [`TBA_NCH-1:0] COMPARE_OUTPUT_PIN,
  output logic [`TBA_NFLAG-1:0] TIMER_FLAG_REG,
  output logic [`TBA_NFLAG-1:0] IRQ_REQ,
  output logic AT_BOTTOM,
  output logic AT_MAX,
  output logic AT_TOP
);

  tba_core_t s_q, s_d;
  logic timer_tick;
  logic cap_evt;
  logic [2:0] top_sel;
  logic top_is_cmpa;
  logic pwm_a_top;
  logic [15:0] top_val;
  logic wrap;
  logic wr_lo_cnt;
  logic [`TBA_NFLAG-1:0] flag_set;
  logic [`TBA_NFLAG-1:0] flag_clr;

  // top value chosen by the operating mode
  function automatic logic [15:0] top_of(input logic [2:0] sel, input logic [15:0] cmpa,
                                         input logic [15:0] cap);
    unique case (sel)
      `TBA_TOP_FF: top_of = `TBA_FIX_FF;
      `TBA_TOP_1FF: top_of = `TBA_FIX_1FF;
      `TBA_TOP_3FF: top_of = `TBA_FIX_3FF;
      `TBA_TOP_CMPA: top_of = cmpa;
      `TBA_TOP_CAP: top_of = cap;
      default: top_of = `TBA_MAX;
    endcase
  endfunction

  // compare channel addressed by a byte location, or none
  function automatic logic [2:0] cmp_chan(input logic [3:0] addr);
    unique case (addr)
      `TBA_A_CMPA_L, `TBA_A_CMPA_H: cmp_chan = 3'h0;
      `TBA_A_CMPB_L, `TBA_A_CMPB_H: cmp_chan = 3'h1;
      `TBA_A_CMPC_L, `TBA_A_CMPC_H: cmp_chan = 3'h2;
      default: cmp_chan = 3'h7;
    endcase
  endfunction

  // (RULE_03) tick source select
  // (RULE_04) source and active edge
  tba_tick_sel u_tick (
    .clk(CLK),
    .rst(RST),
    .sel(s_q.ctrl_b[`TBA_CB_CS_HI:`TBA_CB_CS_LO]),
    .prescale_tick(PRESCALE_TICK),
    .ext_pin(EXTERNAL_COUNT_PIN),
    .tick(timer_tick)
  );

  // capture input is off while the capture register defines top
  tba_cap_filter u_cap (
    .clk(CLK),
    .rst(RST),
    .pin(CAPTURE_INPUT_PIN),
    .comp(COMPARATOR_OUT),
    .use_comp(s_q.ctrl_b[`TBA_CB_ACIC]),
    .nc_en(s_q.ctrl_b[`TBA_CB_NCE]),
    .rising(s_q.ctrl_b[`TBA_CB_EDGE]),
    .enable(top_sel != `TBA_TOP_CAP),
    .evt(cap_evt)
  );

  assign top_sel = s_q.ctrl_a[`TBA_CA_TOP_HI:`TBA_CA_TOP_LO];
  assign top_is_cmpa = (top_sel == `TBA_TOP_CMPA);
  assign pwm_a_top = s_q.ctrl_a[`TBA_CA_PWM] && top_is_cmpa;
  assign wr_lo_cnt = BUS_WR && (BUS_ADDR == `TBA_A_CNT_L);

  // next state: counting, compare, capture, then processor access on top
  always_comb begin
    s_d = s_q;
    flag_set = '0;
    flag_clr = '0;
    // (RULE_10) top selection
    top_val = top_of(top_sel, s_q.cmp_act[0], s_q.cap);
    wrap = 1'b0;

    // count step on each timer tick
    if (timer_tick) begin
      if (s_q.ctrl_b[`TBA_CB_DOWN]) begin
        wrap = (s_q.cnt == `TBA_BOTTOM);
        s_d.cnt = wrap ? top_val : s_q.cnt - 16'h0001;
      end else begin
        wrap = (s_q.cnt == top_val);
        s_d.cnt = wrap ? `TBA_BOTTOM : s_q.cnt + 16'h0001;
      end
    end
    flag_set[`TBA_F_OVF] = wrap;

    // (RULE_07) top buffered in pwm
    // pwm modes take new compare values only at a wrap, so the period stays whole
    if (!s_q.ctrl_a[`TBA_CA_PWM] || wrap) begin
      s_d.cmp_act = s_q.cmp_buf;
    end

    // (RULE_05) continuous compare, flag, pin
    for (int i = 0; i < `TBA_NCH; i++) begin
      s_d.match[i] = (s_q.cnt == s_q.cmp_act[i]);
      if (s_d.match[i] && !s_q.match[i]) begin
        flag_set[`TBA_F_CMPA + i] = 1'b1;
        s_d.oc[i] = ~s_q.oc[i];
      end
    end
    // (RULE_07) no A output as top
    if (pwm_a_top) begin
      s_d.oc[0] = 1'b0;
    end

    // (RULE_06) capture the count
    if (cap_evt) begin
      s_d.cap = s_q.cnt;
      flag_set[`TBA_F_CAP] = 1'b1;
    end

    // reads: data is registered, answer one cycle after the strobe
    if (BUS_RD) begin
      s_d.rdata = 8'h00;
      unique case (BUS_ADDR)
        `TBA_A_CNT_L: begin
          s_d.rdata = s_q.cnt[7:0];
          // (RULE_13) high byte into latch
          s_d.temp = s_q.cnt[15:8];
        end
        // (RULE_17) counter high via latch
        `TBA_A_CNT_H: s_d.rdata = s_q.temp;
        `TBA_A_CMPA_L, `TBA_A_CMPB_L, `TBA_A_CMPC_L:
          s_d.rdata = s_q.cmp_buf[cmp_chan(BUS_ADDR)][7:0];
        // (RULE_14) compare high bypasses latch
        `TBA_A_CMPA_H, `TBA_A_CMPB_H, `TBA_A_CMPC_H:
          s_d.rdata = s_q.cmp_buf[cmp_chan(BUS_ADDR)][15:8];
        `TBA_A_CAP_L: begin
          s_d.rdata = s_q.cap[7:0];
          // (RULE_13) capture high to latch
          s_d.temp = s_q.cap[15:8];
        end
        `TBA_A_CAP_H: s_d.rdata = s_q.temp;
        `TBA_A_CTRL_A: s_d.rdata = s_q.ctrl_a;
        `TBA_A_CTRL_B: s_d.rdata = s_q.ctrl_b;
        `TBA_A_CTRL_C: s_d.rdata = s_q.ctrl_c;
        `TBA_A_FLAG: s_d.rdata = {3'h0, s_q.flag};
        `TBA_A_MASK: s_d.rdata = {3'h0, s_q.mask};
        default: s_d.rdata = 8'h00; // unmapped reads return zero
      endcase
    end

    // writes come last so a processor write beats the count step of the same cycle
    if (BUS_WR) begin
      unique case (BUS_ADDR)
        // (RULE_11) one shared high latch
        // (RULE_18) high writes touch latch only
        `TBA_A_CNT_H, `TBA_A_CMPA_H, `TBA_A_CMPB_H, `TBA_A_CMPC_H, `TBA_A_CAP_H:
          s_d.temp = BUS_WDATA;
        // (RULE_12) low write loads both
        `TBA_A_CNT_L: s_d.cnt = {s_q.temp, BUS_WDATA};
        `TBA_A_CMPA_L, `TBA_A_CMPB_L, `TBA_A_CMPC_L:
          s_d.cmp_buf[cmp_chan(BUS_ADDR)] = {s_q.temp, BUS_WDATA};
        // capture is writable only while it defines top
        `TBA_A_CAP_L: begin
          if (top_sel == `TBA_TOP_CAP) begin
            s_d.cap = {s_q.temp, BUS_WDATA};
          end
        end
        // (RULE_01) plain 8-bit controls
        `TBA_A_CTRL_A: s_d.ctrl_a = BUS_WDATA;
        `TBA_A_CTRL_B: s_d.ctrl_b = BUS_WDATA;
        `TBA_A_CTRL_C: s_d.ctrl_c = BUS_WDATA;
        `TBA_A_FLAG: flag_clr = BUS_WDATA[`TBA_NFLAG-1:0];
        `TBA_A_MASK: s_d.mask = BUS_WDATA[`TBA_NFLAG-1:0];
        default: ; // unmapped writes are dropped
      endcase
    end

    // (RULE_02) flags, masked requests
    // a hardware set in the same cycle as a write-one clear is kept
    s_d.flag = (s_q.flag & ~flag_clr) | flag_set;
    s_d.irq = s_d.flag & s_d.mask;

    // (RULE_08) bottom landmark
    s_d.at_bottom = (s_d.cnt == `TBA_BOTTOM);
    // (RULE_09) max landmark
    s_d.at_max = (s_d.cnt == `TBA_MAX);
    s_d.at_top = (s_d.cnt == top_val);
  end

  // all state in one register
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q <= '0;
      // the count resets to zero, so bottom is already reached
      s_q.at_bottom <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign BUS_RDATA = s_q.rdata;
  assign COMPARE_OUTPUT_PIN = s_q.oc;
  assign TIMER_FLAG_REG = s_q.flag;
  assign IRQ_REQ = s_q.irq;
  assign AT_BOTTOM = s_q.at_bottom;
  assign AT_MAX = s_q.at_max;
  assign AT_TOP = s_q.at_top;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_high_then_low(logic [3:0] hi, logic [3:0] lo);
    (BUS_WR && BUS_ADDR == hi) ##1 (BUS_WR && BUS_ADDR == lo);
  endsequence

  // (RULE_12) pair lands in one cycle
  a_pair_write: assert property (s_high_then_low(`TBA_A_CMPB_H, `TBA_A_CMPB_L) |=> // RULE_12
    s_q.cmp_buf[1] == {$past(BUS_WDATA, 2), $past(BUS_WDATA)})
    else $error("compare pair write did not land whole");

  // (RULE_12) counter low write wins
  a_cnt_low_write: assert property (wr_lo_cnt |=> // RULE_12
    s_q.cnt == {$past(s_q.temp), $past(BUS_WDATA)}) else $error("counter low write lost");

  // (RULE_18) high write keeps target
  a_high_only_latch: assert property (BUS_WR && BUS_ADDR == `TBA_A_CMPA_H |=> // RULE_18
    $stable(s_q.cmp_buf[0]) && s_q.temp == $past(BUS_WDATA))
    else $error("high write disturbed the compare register");

  // (RULE_13) low read then high read
  a_read_pair: assert property (BUS_RD && BUS_ADDR == `TBA_A_CNT_L && !BUS_WR ##1 // RULE_13
    BUS_RD && BUS_ADDR == `TBA_A_CNT_H && !BUS_WR |=> BUS_RDATA == $past(s_q.cnt[15:8], 2))
    else $error("counter high read not from latched copy");

  // (RULE_14) compare high read direct
  a_cmp_high_read: assert property (BUS_RD && BUS_ADDR == `TBA_A_CMPC_H |=> // RULE_14
    BUS_RDATA == $past(s_q.cmp_buf[2][15:8]) && $stable(s_q.temp))
    else $error("compare high read went through the latch");

  // (RULE_03) idle with no source
  a_idle_count: assert property (s_q.ctrl_b[`TBA_CB_CS_HI:`TBA_CB_CS_LO] == `TBA_CS_STOP // RULE_03
    && $past(s_q.ctrl_b[`TBA_CB_CS_HI:`TBA_CB_CS_LO]) == `TBA_CS_STOP && !wr_lo_cnt
    |=> $stable(s_q.cnt)) else $error("counter moved while stopped");

  // (RULE_08) bottom tracks count
  a_bottom_flag: assert property (AT_BOTTOM == (s_q.cnt == `TBA_BOTTOM)) // RULE_08
    else $error("bottom indication wrong");

  // (RULE_09) max tracks count
  a_max_flag: assert property (AT_MAX == (s_q.cnt == `TBA_MAX)) // RULE_09
    else $error("max indication wrong");

  // (RULE_05) new match sets flag
  a_match_flag: assert property (s_q.cnt == s_q.cmp_act[1] && !s_q.match[1] |=> // RULE_05
    TIMER_FLAG_REG[`TBA_F_CMPA + 1]) else $error("compare match flag not set");

  // (RULE_06) capture stores count
  a_capture_store: assert property (cap_evt && !(BUS_WR && BUS_ADDR == `TBA_A_CAP_L) |=> // RULE_06
    s_q.cap == $past(s_q.cnt) && TIMER_FLAG_REG[`TBA_F_CAP])
    else $error("capture did not store the count");

  // (RULE_07) no A output as top
  a_pwm_a_quiet: assert property (pwm_a_top |=> !COMPARE_OUTPUT_PIN[0]) // RULE_07
    else $error("channel A drove output while defining top");

  // (RULE_02) masked flag raises request
  a_irq_gate: assert property (IRQ_REQ == (TIMER_FLAG_REG & s_q.mask)) // RULE_02
    else $error("request does not follow flag and mask");

endmodule

`default_nettype wire

/* tba_cpu_model.sv */
// processor model on the timer byte port: single bytes and ordered 16-bit pairs
`timescale 1ns/1ps
`default_nettype none

module tba_cpu_model
  import tba_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [3:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  // bus idle at time zero
  initial begin
    addr = 4'hf;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one strobe from falling edge to falling edge; released lines show the inverse
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask

  // read byte is taken one edge after the strobe, at release
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    addr = ~a;
    d = rdata;
  endtask

  // pair never split
  // strobe held over both bytes so the pair goes out back to back
  task automatic wr16(input logic [3:0] a_lo, input logic [15:0] d);
    @(negedge clk);
    addr = a_lo + 4'h1;
    wdata = d[15:8];
    wr = 1'b1;
    @(negedge clk);
    addr = a_lo;
    wdata = d[7:0];
    @(negedge clk);
    wr = 1'b0;
    addr = ~a_lo;
    wdata = ~d[7:0];
  endtask

  // pair never split
  // each byte is taken one edge after its strobe, strobe held between them
  task automatic rd16(input logic [3:0] a_lo, output logic [15:0] d);
    @(negedge clk);
    addr = a_lo;
    rd = 1'b1;
    @(negedge clk);
    d[7:0] = rdata;
    addr = a_lo + 4'h1;
    @(negedge clk);
    d[15:8] = rdata;
    rd = 1'b0;
    addr = ~a_lo;
  endtask
endmodule

`default_nettype wire

/* test_timer16_byte_access_path.sv */
// self-checking bench for the 16-bit timer byte path
`timescale 1ns/1ps
`default_nettype none
`include "tba_defines.svh"

module test_timer16_byte_access_path
  import tba_pkg::*;
;
  logic clk;
  logic rst;
  logic pre_tick;
  logic ext_pin;
  logic cap_pin;
  logic comp_out;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [2:0] oc_pin;
  logic [4:0] flags;
  logic [4:0] irq;
  logic at_bottom;
  logic at_max;
  logic at_top;
  logic [6:0] watch;
  logic [15:0] v;
  logic [7:0] b;
  logic pin_b;
  int n_fail;
  int tests_run;
  int cycles;
  logic [15:0] tops [6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff, 16'h0040, 16'h0030};
  logic [3:0] srcs [5] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'ha};
  logic [15:0] ends [5] = '{16'h0100, 16'h0104, 16'h0102, 16'h0102, 16'h00fc};

  assign watch = {flags, at_bottom, at_top};

  tba_timer16 DUT (
    .CLK(clk), .RST(rst), .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd),
    .PRESCALE_TICK(pre_tick), .EXTERNAL_COUNT_PIN(ext_pin), .CAPTURE_INPUT_PIN(cap_pin),
    .COMPARATOR_OUT(comp_out), .BUS_RDATA(rdata), .COMPARE_OUTPUT_PIN(oc_pin),
    .TIMER_FLAG_REG(flags), .IRQ_REQ(irq), .AT_BOTTOM(at_bottom), .AT_MAX(at_max),
    .AT_TOP(at_top)
  );

  tba_cpu_model cpu (
    .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd)
  );

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait on one watched bit, then demand it high
  task automatic wait_on(input int idx, input int lim, input string nm);
    for (int i = 0; i < lim && watch[idx] !== 1'b1; i++) @(negedge clk);
    check(nm, 16'(watch[idx]), 16'h0001);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run;
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pre_tick = 1'b0;
    ext_pin = 1'b0;
    cap_pin = 1'b0;
    comp_out = 1'b0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("bottom after reset", 16'(at_bottom), 16'h0001);
    // zero count meets the zero compares, so matches a..c flag; mask keeps requests off
    check("flags after reset", 16'({flags, irq}), 16'h01c0);
    // high write alone leaves the count; pair loads both bytes; stopped count stays
    cpu.wr16(`TBA_A_CNT_L, 16'h01ff);
    cpu.wr8(`TBA_A_CNT_H, 8'h37);
    repeat (5) @(negedge clk);
    cpu.rd16(`TBA_A_CNT_L, v);
    check("count pair", v, 16'h01ff);
    // latch is shared: a compare high write shows at the count high location
    cpu.wr8(`TBA_A_CMPA_H, 8'hab);
    cpu.rd8(`TBA_A_CNT_H, b);
    check("shared latch", 16'(b), 16'h00ab);
    cpu.wr8(`TBA_A_CNT_L, 8'h22);
    cpu.rd16(`TBA_A_CNT_L, v);
    check("low write uses latch", v, 16'hab22);
    // compare reads come straight from the register and leave the latch alone
    cpu.wr16(`TBA_A_CMPC_L, 16'h5678);
    cpu.wr8(`TBA_A_CNT_H, 8'h99);
    cpu.rd16(`TBA_A_CMPC_L, v);
    check("compare bypass", v, 16'h5678);
    cpu.wr8(`TBA_A_CTRL_C, 8'h5a);
    cpu.rd8(`TBA_A_CNT_H, b);
    check("latch untouched", 16'(b), 16'h0099);
    cpu.rd8(`TBA_A_CTRL_C, b);
    check("plain control byte", 16'(b), 16'h005a);
    cpu.wr8(`TBA_A_MASK, 8'hff);
    cpu.rd8(`TBA_A_MASK, b);
    check("mask reserved bits", 16'(b), 16'h001f);
    cpu.rd8(4'hf, b);
    check("unmapped read", 16'(b), 16'h0000);
    cpu.wr8(`TBA_A_MASK, 8'h00);
    // every top selection: reach top, wrap to bottom, set the wrap flag
    for (int i = 0; i < 6; i++) begin
      cpu.wr8(`TBA_A_CTRL_B, 8'h00);
      cpu.wr8(`TBA_A_CTRL_A, 8'(i));
      if (i == 4) cpu.wr16(`TBA_A_CMPA_L, tops[i]);
      if (i == 5) cpu.wr16(`TBA_A_CAP_L, tops[i]);
      cpu.wr16(`TBA_A_CNT_L, tops[i] - 16'h0003);
      cpu.wr8(`TBA_A_FLAG, 8'h1f);
      cpu.wr8(`TBA_A_CTRL_B, {5'h00, `TBA_CS_CLK});
      wait_on(0, 12, "top reached");
      check("max only at ffff", 16'(at_max), 16'(i == 0));
      wait_on(1, 3, "bottom after top");
      check("wrap flag", 16'(flags[`TBA_F_OVF]), 16'h0001);
    end
    // tick sources and direction: four prescaler pulses, two edges of each kind
    cpu.wr8(`TBA_A_CTRL_A, 8'h00);
    for (int i = 0; i < 5; i++) begin
      cpu.wr8(`TBA_A_CTRL_B, 8'h00);
      cpu.wr16(`TBA_A_CNT_L, 16'h0100);
      cpu.wr8(`TBA_A_CTRL_B, {4'h0, srcs[i]});
      for (int k = 0; k < 4; k++) begin
        @(negedge clk) pre_tick = 1'b1;
        @(negedge clk) pre_tick = 1'b0;
        ext_pin = ~ext_pin;
        repeat (8) @(negedge clk);
      end
      cpu.wr8(`TBA_A_CTRL_B, 8'h00);
      cpu.rd16(`TBA_A_CNT_L, v);
      check("count per source", v, ends[i]);
    end
    // compare B match sets its flag, toggles its pin, request only where unmasked
    cpu.wr16(`TBA_A_CMPB_L, 16'h0008);
    cpu.wr16(`TBA_A_CNT_L, 16'h0004);
    cpu.wr8(`TBA_A_FLAG, 8'h1f);
    cpu.wr8(`TBA_A_MASK, 8'h04);
    pin_b = oc_pin[1];
    cpu.wr8(`TBA_A_CTRL_B, {5'h00, `TBA_CS_CLK});
    wait_on(4, 12, "match b flag");
    check("match b pin", 16'(oc_pin[1]), {15'h0000, ~pin_b});
    check("masked request", 16'(irq), 16'h0004);
    cpu.wr8(`TBA_A_MASK, 8'h00);
    check("flag kept, request off", 16'({flags[2], irq}), 16'h0020);
    // compare A as pwm top: no output on channel A
    cpu.wr8(`TBA_A_CTRL_B, 8'h00);
    cpu.wr16(`TBA_A_CMPA_L, 16'h0020);
    cpu.wr16(`TBA_A_CNT_L, 16'h0000);
    cpu.wr8(`TBA_A_CTRL_A, 8'h0c);
    cpu.wr8(`TBA_A_FLAG, 8'h1f);
    cpu.wr8(`TBA_A_CTRL_B, {5'h00, `TBA_CS_CLK});
    wait_on(3, 40, "match a flag");
    repeat (40) @(negedge clk);
    check("pwm top pin a", 16'(oc_pin[0]), 16'h0000);
    check("wrap at compare a", 16'(flags[`TBA_F_OVF]), 16'h0001);
    // capture from pin, rising edge, no filter, counter stopped
    cpu.wr8(`TBA_A_CTRL_B, 8'h00);
    cpu.wr8(`TBA_A_CTRL_A, 8'h00);
    cpu.wr16(`TBA_A_CNT_L, 16'h0abc);
    cpu.wr8(`TBA_A_CTRL_B, 8'h20);
    repeat (8) @(negedge clk);
    cpu.wr8(`TBA_A_FLAG, 8'h1f);
    cap_pin = 1'b1;
    wait_on(6, 12, "capture flag");
    cpu.rd16(`TBA_A_CAP_L, v);
    check("captured count", v, 16'h0abc);
    // comparator source through the filter: a short glitch is dropped
    cpu.wr16(`TBA_A_CNT_L, 16'h0def);
    cpu.wr8(`TBA_A_CTRL_B, 8'h70);
    repeat (8) @(negedge clk);
    cpu.wr8(`TBA_A_FLAG, 8'h1f);
    comp_out = 1'b1;
    repeat (2) @(negedge clk);
    comp_out = 1'b0;
    repeat (12) @(negedge clk);
    check("glitch filtered", 16'(flags[`TBA_F_CAP]), 16'h0000);
    comp_out = 1'b1;
    wait_on(6, 16, "filtered capture");
    cpu.rd16(`TBA_A_CAP_L, v);
    check("comparator capture", v, 16'h0def);
    complete_run;
  end
endmodule

`default_nettype wire
